// file: src/isr_dev_end.sv
`timescale 1ns/1ps
module isr_dev_end
   import isr_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   isr_bus_if.dev bus,
   input wire logic address_select_pin,
   output logic bus_busy,
   output logic [7:0] register_pointer,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid
);
   logic [2:0] pin_s;
   logic scl_s;
   logic sda_s;
   logic sel_s;
   logic scl_q_reg;
   logic sda_q_reg;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic byte_done;
   logic [6:0] own_addr;
   isr_dev_state_t state_reg;
   isr_phase_t phase_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic read_mode_reg;
   logic m_ack_reg;
   logic [7:0] ptr_reg;

   // Bus pins and the select strap all come from outside the clock domain
   isr_sync #(.WIDTH(3)) u_sync
   (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .din({bus.scl, bus.sda, address_select_pin}),
      .dout(pin_s)
   );

   assign scl_s = pin_s[2];
   assign sda_s = pin_s[1];
   assign sel_s = pin_s[0];

   // Delayed copies of the synchronised lines for edge finding
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end
      else
      begin
         scl_q_reg <= scl_s;
         sda_q_reg <= sda_s;
      end
   end

   // Bus conditions; a start or stop never coincides with a clock edge
   assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s; // R5
   assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s; // R6
   assign scl_rise = scl_s & ~scl_q_reg;
   assign scl_fall = ~scl_s & scl_q_reg;
   assign byte_done = (state_reg == DEV_RX) && scl_rise && (bit_cnt_reg == ISR_LAST_BIT); // R8

   // Pin level read live, so a strap change takes effect on the next address
   assign own_addr = {ISR_ADDR_BASE, sel_s}; // R3 R4

   // Main sequencer; start and stop override every state
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= DEV_IDLE;
      end
      else if (start_det)
      begin
         state_reg <= DEV_RX; // R7
      end
      else if (stop_det)
      begin
         state_reg <= DEV_IDLE; // R6
      end
      else
      begin
         unique case (state_reg)
            DEV_IDLE:
            begin
               state_reg <= DEV_IDLE; // R1
            end
            DEV_RX:
            begin
               if (byte_done)
               begin
                  // Foreign address: stay silent until the next start
                  if (phase_reg == PH_ADDR && shift_reg[6:0] != own_addr)
                  begin
                     state_reg <= DEV_IDLE; // R18 R20
                  end
                  else
                  begin
                     state_reg <= DEV_ACK_SETUP;
                  end
               end
            end
            DEV_ACK_SETUP:
            begin
               // Wait for clock low before pulling data, keeps data stable while high
               if (scl_fall)
               begin
                  state_reg <= DEV_ACK; // R13
               end
            end
            DEV_ACK:
            begin
               if (scl_fall)
               begin
                  state_reg <= read_mode_reg ? DEV_FETCH : DEV_RX; // R16
               end
            end
            DEV_FETCH:
            begin
               if (reg_rd_valid)
               begin
                  state_reg <= DEV_TX;
               end
            end
            DEV_TX:
            begin
               if (scl_fall && bit_cnt_reg == ISR_LAST_BIT)
               begin
                  state_reg <= DEV_TX_ACK;
               end
            end
            DEV_TX_ACK:
            begin
               // Master nack ends the read; only a stop or start follows
               if (scl_fall)
               begin
                  state_reg <= m_ack_reg ? DEV_FETCH : DEV_IDLE; // R17
               end
            end
            // Unused code 3'b111: fall back to idle rather than lock up
            default:
            begin
               state_reg <= DEV_IDLE;
            end
         endcase
      end
   end

   // Bit counter: rising edges while receiving, falling edges while sending
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_cnt_reg <= 3'h0;
      end
      else if (start_det)
      begin
         bit_cnt_reg <= 3'h0;
      end
      else if ((state_reg == DEV_RX && scl_rise) || (state_reg == DEV_TX && scl_fall))
      begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1; // R8
      end
      else if (state_reg != DEV_RX && state_reg != DEV_TX)
      begin
         bit_cnt_reg <= 3'h0;
      end
   end

   // Shift register, MSB first in both directions
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shift_reg <= 8'h00;
      end
      else if (state_reg == DEV_RX && scl_rise)
      begin
         shift_reg <= {shift_reg[6:0], sda_s};
      end
      else if (state_reg == DEV_FETCH && reg_rd_valid)
      begin
         shift_reg <= reg_rd_data;
      end
      else if (state_reg == DEV_TX && scl_fall)
      begin
         shift_reg <= {shift_reg[6:0], 1'b0};
      end
   end

   // Byte role: address, then pointer, then data; a restart goes back to address
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_reg <= PH_ADDR;
         read_mode_reg <= 1'b0;
      end
      else if (start_det)
      begin
         phase_reg <= PH_ADDR; // R7
         read_mode_reg <= 1'b0;
      end
      else if (byte_done)
      begin
         if (phase_reg == PH_ADDR)
         begin
            read_mode_reg <= sda_s; // R16
            phase_reg <= PH_PTR; // R14
         end
         else
         begin
            phase_reg <= PH_DATA;
         end
      end
   end

   // Master acknowledge on our sent byte, sampled at the ninth high
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         m_ack_reg <= 1'b0;
      end
      else if (state_reg == DEV_TX_ACK && scl_rise)
      begin
         m_ack_reg <= ~sda_s; // R17
      end
   end

   // Pointer survives a restart so a read follows the pointer write
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ptr_reg <= ISR_PTR_RST;
      end
      else if (byte_done && phase_reg == PH_PTR)
      begin
         ptr_reg <= {shift_reg[6:0], sda_s}; // R14
      end
      else if (reg_wr_en)
      begin
         ptr_reg <= ptr_reg + 8'h01; // R15
      end
      else if (state_reg == DEV_FETCH && reg_rd_valid)
      begin
         ptr_reg <= ptr_reg + 8'h01; // R19
      end
   end

   // Write strobe one cycle after the eighth data bit, pointer bumps after it
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_wr_en <= 1'b0;
         reg_wr_data <= 8'h00;
      end
      else
      begin
         reg_wr_en <= byte_done && phase_reg == PH_DATA; // R14 R15
         if (byte_done && phase_reg == PH_DATA)
         begin
            reg_wr_data <= {shift_reg[6:0], sda_s};
         end
      end
   end

   // Read request on each entry to fetch
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rd_en <= 1'b0;
      end
      else
      begin
         reg_rd_en <= scl_fall && ((state_reg == DEV_ACK && read_mode_reg) ||
                                   (state_reg == DEV_TX_ACK && m_ack_reg)); // R16 R19
      end
   end

   // Busy flag, not cleared by a repeated start
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_busy <= 1'b0;
      end
      else if (start_det)
      begin
         bus_busy <= 1'b1; // R7
      end
      else if (stop_det)
      begin
         bus_busy <= 1'b0; // R6
      end
   end

   assign register_pointer = ptr_reg;

   // Open-drain drives; clock held low while data is fetched
   assign bus.s_scl_o = 1'b0;
   assign bus.s_sda_o = 1'b0;
   assign bus.s_scl_oe = (state_reg == DEV_FETCH); // R10
   assign bus.s_sda_oe = (state_reg == DEV_ACK) || (state_reg == DEV_TX && !shift_reg[7]); // R9
endmodule

// file: pkg/isr_pkg.sv
// Functional notes
// R1: Device is always target, never initiates.
// R2: Master keeps serial clock at most 400 kHz.
// R3: Device address is 110100 plus select pin.
// R4: Select low gives 1101000, high gives 1101001.
// R5: Start is data falling while clock high.
// R6: Stop is data rising while clock high.
// R7: Busy from start to stop; restart stays busy.
// R8: Bytes are eight bits, count unlimited.
// R9: Receiver holds data low during ninth clock.
// R10: Device may hold clock low; master waits.
// R11: Master sends address then direction bit.
// R12: Master releases data for address acknowledge.
// R13: Data changes only while clock is low.
// R14: Write: address, pointer, data, each acknowledged.
// R15: Burst write increments pointer after each byte.
// R16: Read: pointer write, restart, address with read.
// R17: Master acks wanted bytes, nack then stop.
// R18: Restart to other address is ignored here.
// R19: Burst read advances pointer after each byte.
// R20: Address mismatch: no acknowledge, idle until start.
package isr_pkg;

   // Fixed upper six address bits, low bit from the select pin
   localparam logic [5:0] ISR_ADDR_BASE = 6'h34;
   localparam logic [7:0] ISR_PTR_RST = 8'h00;
   localparam logic [2:0] ISR_LAST_BIT = 3'h7;
   localparam logic [3:0] ISR_ACK_BIT_IDX = 4'h8;

   // Serial clock timing, derived from the core clock period
   localparam int ISR_CLK_PERIOD_NS = 4;
   localparam int ISR_SCL_MAX_KHZ = 400;
   localparam int ISR_SCL_PERIOD_NS = 1000000 / ISR_SCL_MAX_KHZ;
   localparam int ISR_SCL_QTR_NS = ISR_SCL_PERIOD_NS / 4;
   // Least time, so round up
   localparam int ISR_SCL_QTR_CYC = (ISR_SCL_QTR_NS + ISR_CLK_PERIOD_NS - 1) / ISR_CLK_PERIOD_NS;

   typedef enum logic [2:0]
   {
      DEV_IDLE = 3'b000,
      DEV_RX = 3'b001,
      DEV_ACK_SETUP = 3'b010,
      DEV_ACK = 3'b011,
      DEV_FETCH = 3'b100,
      DEV_TX = 3'b101,
      DEV_TX_ACK = 3'b110
   } isr_dev_state_t;

   typedef enum logic [1:0]
   {
      PH_ADDR = 2'b00,
      PH_PTR = 2'b01,
      PH_DATA = 2'b10
   } isr_phase_t;

   typedef enum logic [1:0]
   {
      CMD_START = 2'b00,
      CMD_STOP = 2'b01,
      CMD_WRITE = 2'b10,
      CMD_READ = 2'b11
   } isr_cmd_t;

   typedef enum logic
   {
      HOST_IDLE = 1'b0,
      HOST_RUN = 1'b1
   } isr_host_state_t;

endpackage

// file: pkg/isr_bus_if.sv
`timescale 1ns/1ps
interface isr_bus_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_scl_o;
   logic s_scl_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // Open-drain wired-AND with pull-ups: any enabled low driver wins
   assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport dev
   (
      input scl,
      input sda,
      output s_scl_o,
      output s_scl_oe,
      output s_sda_o,
      output s_sda_oe
   );

   modport host
   (
      input scl,
      input sda,
      output m_scl_o,
      output m_scl_oe,
      output m_sda_o,
      output m_sda_oe
   );
endinterface

// file: src/isr_sync.sv
`timescale 1ns/1ps
module isr_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;

   if (WIDTH < 1)
   begin : g_chk
      $error("isr_sync: WIDTH must be at least 1");
   end

   // Two stages; the first feeds only the second. Idle bus level is high.
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= '1;
         dout <= '1;
      end
      else
      begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule

// file: src/isr_host_end.sv
`timescale 1ns/1ps
module isr_host_end
   import isr_pkg::*;
#(
   parameter int QTR_CYC = ISR_SCL_QTR_CYC
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   isr_bus_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire isr_cmd_t cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_nack
);
   localparam int CW = $clog2(QTR_CYC + 1);
   localparam logic [CW-1:0] QTR_END = CW'(QTR_CYC - 1);

   logic [1:0] pin_s;
   logic scl_s;
   logic sda_s;
   isr_host_state_t state_reg;
   isr_cmd_t op_reg;
   logic [7:0] sh_reg;
   logic last_reg;
   logic [1:0] step_reg;
   logic [3:0] bit_reg;
   logic [CW-1:0] cnt_reg;
   logic scl_rel;
   logic sda_rel;
   logic stall;
   logic step_end;
   logic is_bit_op;
   logic ack_slot;
   logic scl_oe_reg;
   logic sda_oe_reg;

   if (QTR_CYC < 2)
   begin : g_chk
      $error("isr_host_end: QTR_CYC must be at least 2");
   end

   isr_sync #(.WIDTH(2)) u_sync
   (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .din({bus.scl, bus.sda}),
      .dout(pin_s)
   );

   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];
   assign is_bit_op = (op_reg == CMD_WRITE) || (op_reg == CMD_READ);
   assign ack_slot = (bit_reg == ISR_ACK_BIT_IDX);

   // Four quarter steps per bit, nine bits for write and read; write and read data move only in steps with clock low, start and stop move data while it is high
   always_comb
   begin
      scl_rel = (op_reg == CMD_STOP) ? (step_reg != 2'h0) : (step_reg == 2'h1 || step_reg == 2'h2);
      unique case (op_reg)
         CMD_START: sda_rel = (step_reg < 2'h2); // R5 R13
         CMD_STOP: sda_rel = (step_reg >= 2'h2); // R6 R13
         CMD_WRITE: sda_rel = ack_slot ? 1'b1 : sh_reg[7]; // R11 R12
         CMD_READ: sda_rel = ack_slot ? last_reg : 1'b1; // R17
      endcase
   end

   // Released clock held low by the device freezes the quarter timer
   assign stall = scl_rel && !scl_s; // R10
   assign step_end = (state_reg == HOST_RUN) && !stall && (cnt_reg == QTR_END); // R2

   // Command sequencer
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= HOST_IDLE;
         op_reg <= CMD_START;
         last_reg <= 1'b0;
         step_reg <= 2'h0;
         bit_reg <= 4'h0;
      end
      else
      begin
         unique case (state_reg)
            HOST_IDLE:
            begin
               if (cmd_valid)
               begin
                  state_reg <= HOST_RUN;
                  op_reg <= cmd_op;
                  last_reg <= cmd_last;
                  step_reg <= 2'h0;
                  bit_reg <= 4'h0;
               end
            end
            HOST_RUN:
            begin
               if (step_end)
               begin
                  step_reg <= step_reg + 2'h1;
                  if (step_reg == 2'h3)
                  begin
                     if (is_bit_op && !ack_slot)
                     begin
                        bit_reg <= bit_reg + 4'h1; // R8 R9
                     end
                     else
                     begin
                        state_reg <= HOST_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Quarter timer
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg <= '0;
      end
      else if (state_reg != HOST_RUN || step_end)
      begin
         cnt_reg <= '0;
      end
      else if (!stall)
      begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end

   // Data shifter: sample at end of high step, shift out after low step
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh_reg <= 8'h00;
         rsp_nack <= 1'b0;
      end
      else if (state_reg == HOST_IDLE && cmd_valid)
      begin
         sh_reg <= cmd_data;
      end
      else if (step_end && step_reg == 2'h2 && ack_slot && op_reg == CMD_WRITE)
      begin
         rsp_nack <= sda_s; // R9
      end
      else if (step_end && step_reg == 2'h2 && !ack_slot && op_reg == CMD_READ)
      begin
         sh_reg <= {sh_reg[6:0], sda_s};
      end
      else if (step_end && step_reg == 2'h3 && !ack_slot && op_reg == CMD_WRITE)
      begin
         sh_reg <= {sh_reg[6:0], 1'b0};
      end
   end

   // Pin drives; they hold their last level between commands
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         rsp_valid <= 1'b0;
      end
      else
      begin
         rsp_valid <= step_end && step_reg == 2'h3 && !(is_bit_op && !ack_slot);
         if (state_reg == HOST_RUN)
         begin
            scl_oe_reg <= !scl_rel;
            sda_oe_reg <= !sda_rel;
         end
      end
   end

   assign cmd_ready = (state_reg == HOST_IDLE);
   assign rsp_data = sh_reg;
   assign bus.m_scl_o = 1'b0;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_scl_oe = scl_oe_reg;
   assign bus.m_sda_oe = sda_oe_reg;
endmodule

// file: dv/isr_props.sv
`timescale 1ns/1ps
module isr_props
   import isr_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic address_select_pin,
   input wire logic scl,
   input wire logic sda,
   input wire logic m_sda_oe,
   input wire logic s_scl_oe,
   input wire logic s_sda_oe
);
   logic scl_reg;
   logic sda_reg;
   logic first_reg;
   logic nomatch_reg;
   logic rw_reg;
   logic [3:0] cnt_reg;
   logic [7:0] addr_reg;
   logic start_w;
   logic rise_w;
   logic rise9_w;
   logic match_w;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // Line events as the core clock sees them
   assign start_w = scl & scl_reg & sda_reg & ~sda;
   assign rise_w = scl & ~scl_reg;
   assign rise9_w = rise_w & (cnt_reg == 4'h8);
   assign match_w = (addr_reg[7:1] == {ISR_ADDR_BASE, address_select_pin});

   // Previous levels; a released bus idles high
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end
      else
      begin
         scl_reg <= scl;
         sda_reg <= sda;
      end
   end

   // Clock rises within a byte; stray rises before a restart are harmless
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg <= 4'h0;
      end
      else if (start_w)
      begin
         cnt_reg <= 4'h0;
      end
      else if (rise_w)
      begin
         cnt_reg <= (cnt_reg >= 4'h9) ? 4'h1 : cnt_reg + 4'h1;
      end
   end

   // Address byte capture, direction and match outcome
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         first_reg <= 1'b0;
         nomatch_reg <= 1'b0;
         rw_reg <= 1'b0;
         addr_reg <= 8'h00;
      end
      else if (start_w)
      begin
         first_reg <= 1'b1;
         nomatch_reg <= 1'b0;
      end
      else if (rise9_w && first_reg)
      begin
         first_reg <= 1'b0;
         rw_reg <= addr_reg[0];
         nomatch_reg <= ~match_w;
      end
      else if (rise_w && first_reg)
      begin
         addr_reg <= {addr_reg[6:0], sda};
      end
   end

   a_addr_ack_match: assert property (rise9_w && first_reg |-> s_sda_oe == match_w)
      else $error("address acknowledge does not follow the address match");
   a_idle_on_miss: assert property (nomatch_reg |-> !s_sda_oe && !s_scl_oe)
      else $error("device drives the bus after a foreign address");
   a_addr_quiet: assert property (first_reg && cnt_reg < 4'h8 |-> !s_sda_oe)
      else $error("device drives data during the address bits");
   a_sda_steady_high: assert property (scl && scl_reg |-> $stable(s_sda_oe))
      else $error("device changes data while the clock is high");
   a_host_ack_free: assert property (rise9_w && (first_reg || !rw_reg) |-> !m_sda_oe)
      else $error("host holds data in the device acknowledge slot");
   a_dev_ack_free: assert property (rise9_w && !first_reg && rw_reg |-> !s_sda_oe)
      else $error("device holds data in the host acknowledge slot");
   a_stretch_low: assert property ($rose(s_scl_oe) |-> !$past(scl))
      else $error("device pulls the clock while it is high");
   a_scl_high_min: assert property ($rose(scl) |-> scl[*6])
      else $error("clock high phase too short");
   a_scl_low_min: assert property ($fell(scl) |-> !scl[*6])
      else $error("clock low phase too short");
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top
   import isr_pkg::*;
;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic address_select_pin = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   isr_cmd_t cmd_op = CMD_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_last = 1'b0;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_nack;
   logic bus_busy;
   logic [7:0] register_pointer;
   logic reg_wr_en;
   logic [7:0] reg_wr_data;
   logic reg_rd_en;
   logic [7:0] reg_rd_data = 8'h00;
   logic reg_rd_valid = 1'b0;
   logic [7:0] mem [256];
   logic [7:0] pat [3] = '{8'ha5, 8'h3c, 8'h96};
   int rd_delay = 0;
   int rd_cnt = -1;
   int wr_count = 0;
   int err_total = 0;
   int checks = 0;
   int n;

   // 250 MHz core clock
   always #2 core_clk = ~core_clk;

   isr_bus_if bus();
   isr_dev_end u_isr_dev_end
   (
      .core_clk(core_clk), .arst_n(arst_n), .bus(bus),
      .address_select_pin(address_select_pin), .bus_busy(bus_busy),
      .register_pointer(register_pointer), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
      .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid)
   );
   // Short quarter period keeps the run brief
   isr_host_end #(.QTR_CYC(8)) u_isr_host_end
   (
      .core_clk(core_clk), .arst_n(arst_n), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_nack(rsp_nack)
   );
   isr_props u_isr_props
   (
      .core_clk(core_clk), .arst_n(arst_n), .address_select_pin(address_select_pin),
      .scl(bus.scl), .sda(bus.sda), .m_sda_oe(bus.m_sda_oe),
      .s_scl_oe(bus.s_scl_oe), .s_sda_oe(bus.s_sda_oe)
   );

   // Register file behind the device; idle read data toggles so stale bytes show
   always @(negedge core_clk)
   begin
      if (reg_wr_en === 1'b1)
      begin
         mem[register_pointer] = reg_wr_data;
         wr_count++;
      end
      if (rd_cnt == 0)
      begin
         reg_rd_valid = 1'b1;
         reg_rd_data = mem[register_pointer];
      end
      else
      begin
         reg_rd_valid = 1'b0;
         reg_rd_data = ~reg_rd_data;
      end
      if (reg_rd_en === 1'b1)
         rd_cnt = rd_delay;
      else
         rd_cnt = (rd_cnt >= 0) ? rd_cnt - 1 : -1;
   end

   task automatic results();
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic stall();
      err_total++;
      results();
   endtask

   // One host command: raise valid only when ready, then wait for the response
   task automatic host_cmd(input isr_cmd_t op, input logic [7:0] d, input logic last);
      int k;
      k = 0;
      @(negedge core_clk);
      while (cmd_ready !== 1'b1 && k < 50)
      begin
         @(negedge core_clk);
         k++;
      end
      // A host that never comes back to idle is a hang, not a pass
      if (k >= 50)
         stall();
      cmd_op = op;
      cmd_data = d;
      cmd_last = last;
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 3000)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 3000)
         stall();
   endtask

   task automatic wr_byte(input logic [7:0] d, input logic exp_nack);
      host_cmd(CMD_WRITE, d, 1'b0);
      `CHK(rsp_nack, exp_nack);
   endtask

   task automatic rd_byte(input logic last, input logic [7:0] exp);
      host_cmd(CMD_READ, 8'h00, last);
      `CHK(rsp_data, exp);
   endtask

   // Busy follows the lines through the synchroniser, so allow a few cycles
   task automatic expect_busy(input logic v);
      int k;
      for (k = 0; k < 20 && bus_busy !== v; k++)
         @(negedge core_clk);
      `CHK(bus_busy, v);
   endtask

   initial
   begin
      repeat (3) @(negedge core_clk);
      arst_n = 1'b1;
      `CHK(bus_busy, 1'b0);
      `CHK(register_pointer, ISR_PTR_RST);
      // Burst write across the pointer wrap
      host_cmd(CMD_START, 8'h00, 1'b0);
      expect_busy(1'b1);
      wr_byte(8'hd0, 1'b0);
      wr_byte(8'hfe, 1'b0);
      for (int i = 0; i < 3; i++)
         wr_byte(pat[i], 1'b0);
      host_cmd(CMD_STOP, 8'h00, 1'b0);
      expect_busy(1'b0);
      `CHK({bus.scl, bus.sda}, 2'b11);
      for (int i = 0; i < 3; i++)
         `CHK(mem[8'hfe + 8'(i)], pat[i]);
      `CHK(register_pointer, 8'h01);
      // Burst read back while the device stretches the clock
      rd_delay = 40;
      host_cmd(CMD_START, 8'h00, 1'b0);
      wr_byte(8'hd0, 1'b0);
      wr_byte(8'hfe, 1'b0);
      host_cmd(CMD_START, 8'h00, 1'b0);
      `CHK(bus_busy, 1'b1);
      wr_byte(8'hd1, 1'b0);
      for (int i = 0; i < 3; i++)
         rd_byte(i == 2, pat[i]);
      host_cmd(CMD_STOP, 8'h00, 1'b0);
      `CHK(register_pointer, 8'h01);
      // Foreign address: no acknowledge, no register traffic
      n = wr_count;
      host_cmd(CMD_START, 8'h00, 1'b0);
      wr_byte(8'hd2, 1'b1);
      wr_byte(8'h00, 1'b1);
      host_cmd(CMD_STOP, 8'h00, 1'b0);
      `CHK(wr_count, n);
      // Select pin high moves the device to the odd address
      address_select_pin = 1'b1;
      host_cmd(CMD_START, 8'h00, 1'b0);
      wr_byte(8'hd2, 1'b0);
      wr_byte(8'h10, 1'b0);
      wr_byte(8'h77, 1'b0);
      host_cmd(CMD_START, 8'h00, 1'b0);
      wr_byte(8'hd0, 1'b1);
      wr_byte(8'h55, 1'b1);
      host_cmd(CMD_STOP, 8'h00, 1'b0);
      expect_busy(1'b0);
      `CHK(mem[8'h10], 8'h77);
      `CHK(wr_count, n + 1);
      results();
   end
endmodule
